// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0;
	logic [7:0] reg_wdata = 8'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic in_byte_loaded = 1'b0;
	logic out_byte_unloaded = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_is_in = 1'b0;
	logic cmd_iso = 1'b0;
	logic [2:0] cmd_ep = 3'h1;
	logic [10:0] cmd_len = 11'h0;
	logic cmd_err = 1'b0;
	logic [7:0] reg_rdata;
	logic irq, cmd_ready, res_valid, res_data1, res_timeout;
	ubiec_pkg::ubiec_hs_t res_code;
	int miscompares = 0, n_checks = 0, dtog = 0, htog = 0, itog = 0, i;
	int unsigned seed = 28;
	int q[$];
	logic sent = 1'b0, req = 1'b0, erf = 1'b0, ovr = 1'b0;
	logic [2:0] ep;

	ubiec_link_if lnk ();
	ubiec_device u_ubiec_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.dev),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_byte_loaded(in_byte_loaded),
		.out_byte_unloaded(out_byte_unloaded), .irq(irq));
	ubiec_host u_ubiec_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.host),
		.cmd_valid(cmd_valid), .cmd_is_in(cmd_is_in), .cmd_iso(cmd_iso), .cmd_ep(cmd_ep),
		.cmd_len(cmd_len), .cmd_err(cmd_err), .cmd_ready(cmd_ready), .res_valid(res_valid),
		.res_code(res_code), .res_data1(res_data1), .res_timeout(res_timeout));
	ubiec_link_assertions u_ubiec_link_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
		.tok_valid(lnk.tok_valid), .tok_kind(lnk.tok_kind), .tok_ep(lnk.tok_ep),
		.tok_data1(lnk.tok_data1), .tok_len(lnk.tok_len), .tok_err(lnk.tok_err),
		.hs_valid(lnk.hs_valid), .hs_code(lnk.hs_code), .hs_data1(lnk.hs_data1));

	always #5 clk_sys = ~clk_sys;

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic results();
		if (miscompares == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask

	// exp packs {timeout, data1, code}; the code is stale on a timeout
	task automatic xact(input logic is_in, input logic iso, input logic [10:0] len,
		input logic err, input logic [3:0] exp);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_is_in <= is_in;
		cmd_iso <= iso;
		cmd_ep <= ep;
		cmd_len <= len;
		cmd_err <= err;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		for (i = 0; i < 40 && res_valid !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 40) begin
			miscompares++;
			results();
		end
		chk8({7'h0, cmd_ready}, 8'h01);
		chk8({4'h0, res_timeout ? 4'h8 :
			{1'b0, res_data1 & (res_code == ubiec_pkg::HS_DATA), res_code}}, {4'h0, exp});
	endtask

	task automatic do_out(input logic iso, input logic err, input logic [10:0] len);
		logic [3:0] e;
		if (req && !iso) begin
			e = {2'h0, ubiec_pkg::HS_STALL};
			sent = 1'b1;
		end else if (iso) begin
			e = 4'h8;
			if (q.size() > 0) ovr = 1'b1;
			else begin
				q.push_back(len);
				erf = err;
			end
		end else if (q.size() > 0) e = {2'h0, ubiec_pkg::HS_NAK};
		else if (err) e = 4'h8;
		else begin
			e = {2'h0, ubiec_pkg::HS_ACK};
			// a repeated toggle is acked but not kept
			if (htog == dtog) begin
				q.push_back(len);
				dtog ^= 1;
			end
			htog ^= 1;
		end
		xact(1'b0, iso, len, err, e);
	endtask

	task automatic wctl(input logic [7:0] d);
		wr(ubiec_pkg::ADDR_OUT_CTRL_LOW, d);
		if ((d[4] || !d[0]) && q.size() > 0) begin
			void'(q.pop_front());
			erf = 1'b0;
		end
		if (d[7]) dtog = 0;
		sent &= d[6];
		ovr &= d[2];
		req = d[5];
	endtask

	task automatic chk_out();
		logic [7:0] c;
		c = q.size() > 0 ? 8'(q[0]) : 8'h0;
		rd(ubiec_pkg::ADDR_OUT_CTRL_LOW,
			{1'b0, sent, req, 1'b0, erf, ovr, {2{q.size() > 0}}});
		rd(ubiec_pkg::ADDR_CNT_LOW, c);
	endtask

	task automatic bytes8(input logic in_side);
		repeat (8) begin
			@(posedge clk_sys);
			in_byte_loaded <= in_side;
			out_byte_unloaded <= !in_side;
		end
		@(posedge clk_sys);
		in_byte_loaded <= 1'b0;
		out_byte_unloaded <= 1'b0;
	endtask

	initial begin
		logic [7:0] m;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		ep = 3'(rnd() % 5 + 1);
		m = 8'(rnd());
		rd(16'hde00, 8'h00);
		rd(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'h00);
		wr(ubiec_pkg::ADDR_EP_SELECT, {5'h0, ep});
		rd(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'h20);
		rd(ubiec_pkg::ADDR_OUT_MAX, 8'h00);
		chk_out();
		wr(ubiec_pkg::ADDR_OUT_MAX, m);
		rd(ubiec_pkg::ADDR_OUT_MAX, m);
		wr(ubiec_pkg::ADDR_OUT_MAX, 8'h08);
		wr(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'he9);
		rd(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'he9);
		wr(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'h20);
		do_out(1'b0, 1'b1, 11'h010);
		do_out(1'b0, 1'b0, 11'(rnd() % 63 + 1));
		chk_out();
		chk8({7'h0, irq}, 8'h00);
		rd(ubiec_pkg::ADDR_IRQ_STATUS, 8'(1 << (ep - 1)));
		wr(ubiec_pkg::ADDR_IRQ_MASK, 8'hff);
		#1;
		chk8({7'h0, irq}, 8'h01);
		do_out(1'b0, 1'b0, 11'(rnd() % 63 + 1));
		wctl(8'h00);
		chk_out();
		wr(ubiec_pkg::ADDR_IRQ_STATUS, 8'hff);
		#1;
		chk8({7'h0, irq}, 8'h00);
		wctl(8'h80);
		chk_out();
		do_out(1'b0, 1'b0, 11'(rnd() % 63 + 1));
		chk_out();
		do_out(1'b0, 1'b0, 11'(rnd() % 63 + 1));
		wctl(8'h11);
		chk_out();
		wctl(8'h20);
		do_out(1'b0, 1'b0, 11'(rnd() % 63 + 1));
		chk_out();
		wr(ubiec_pkg::ADDR_OUT_CONFIG, 8'h40);
		do_out(1'b1, 1'b1, 11'(rnd() % 63 + 1));
		chk_out();
		do_out(1'b1, 1'b0, 11'(rnd() % 63 + 1));
		chk_out();
		wctl(8'h04);
		chk_out();
		wctl(8'h00);
		wr(ubiec_pkg::ADDR_OUT_MAX, 8'h01);
		wr(ubiec_pkg::ADDR_OUT_CONFIG, 8'h80);
		do_out(1'b0, 1'b0, 11'h008);
		bytes8(1'b0);
		void'(q.pop_front());
		chk_out();
		wr(ubiec_pkg::ADDR_IN_MAX, 8'h01);
		wr(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'ha0);
		bytes8(1'b1);
		rd(ubiec_pkg::ADDR_IN_READY, 8'h01);
		xact(1'b1, 1'b0, 11'h0, 1'b0, {1'b0, itog[0], ubiec_pkg::HS_DATA});
		itog ^= 1;
		xact(1'b1, 1'b0, 11'h0, 1'b0, {2'h0, ubiec_pkg::HS_NAK});
		wr(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'ha8);
		bytes8(1'b1);
		xact(1'b1, 1'b0, 11'h0, 1'b0, {1'b0, itog[0], ubiec_pkg::HS_DATA});
		rd(ubiec_pkg::ADDR_IN_READY, 8'h00);
		itog ^= 1;
		wr(ubiec_pkg::ADDR_IN_CTRL_HIGH, 8'h61);
		repeat (2) wr(ubiec_pkg::ADDR_IN_READY, 8'h01);
		xact(1'b1, 1'b1, 11'h0, 1'b0, {1'b0, itog[0], ubiec_pkg::HS_DATA});
		itog ^= 1;
		rd(ubiec_pkg::ADDR_IN_READY, 8'h01);
		xact(1'b1, 1'b1, 11'h0, 1'b0, {1'b0, itog[0], ubiec_pkg::HS_DATA});
		itog ^= 1;
		rd(ubiec_pkg::ADDR_IN_READY, 8'h00);
		xact(1'b1, 1'b1, 11'h0, 1'b0, {2'h0, ubiec_pkg::HS_DATA});
		results();
	end
endmodule

// *** verification/ubiec_link_assertions.sv ***
`timescale 1ns/1ps
module ubiec_link_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tok_valid,
	input wire ubiec_pkg::ubiec_tok_t tok_kind,
	input wire logic [ubiec_pkg::SEL_W-1:0] tok_ep,
	input wire logic tok_data1,
	input wire logic [ubiec_pkg::LEN_W-1:0] tok_len,
	input wire logic tok_err,
	input wire logic hs_valid,
	input wire ubiec_pkg::ubiec_hs_t hs_code,
	input wire logic hs_data1
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_tok_ok;
		tok_valid && tok_ep >= ubiec_pkg::EP_SEL_MIN && tok_ep <= ubiec_pkg::EP_SEL_MAX;
	endsequence
	sequence s_out_tok;
		s_tok_ok ##0 tok_kind == ubiec_pkg::TOK_OUT;
	endsequence

	a_in_answered: assert property (
		s_tok_ok ##0 tok_kind == ubiec_pkg::TOK_IN |=>
		hs_valid && hs_code inside {ubiec_pkg::HS_DATA, ubiec_pkg::HS_NAK})
		else $error("IN token not answered with data or nak");
	a_data_after_in: assert property (
		hs_valid && hs_code == ubiec_pkg::HS_DATA |-> $past(tok_kind) == ubiec_pkg::TOK_IN)
		else $error("data sent without IN token");
	a_stall_on_out: assert property (
		hs_valid && hs_code == ubiec_pkg::HS_STALL |-> $past(tok_kind) == ubiec_pkg::TOK_OUT)
		else $error("stall sent without OUT token");
	a_err_no_ack: assert property (
		s_out_tok ##0 tok_err |=> !hs_valid)
		else $error("handshake for damaged packet");
	a_ack_tok_silent: assert property (
		s_tok_ok ##0 tok_kind == ubiec_pkg::TOK_ACK |=> !hs_valid)
		else $error("handshake after ack token");
	a_hs_after_tok: assert property (
		hs_valid |-> $past(tok_valid))
		else $error("handshake without token one cycle before");
	a_hs_one_cycle: assert property (
		hs_valid |=> !hs_valid)
		else $error("handshake longer than one cycle");
	// quiet handshake lines park at NAK and DATA0
	a_code_idle: assert property (
		!hs_valid |-> hs_code == ubiec_pkg::HS_NAK && !hs_data1)
		else $error("handshake code not parked while idle");
endmodule

// *** verilog/ubiec_device.sv ***
`timescale 1ns/1ps
module ubiec_device (
	input wire logic clk_sys,
	input wire logic rst_n,
	ubiec_link_if.dev link,
	input wire logic [ubiec_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ubiec_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ubiec_pkg::DATA_W-1:0] reg_rdata,
	input wire logic in_byte_loaded,
	input wire logic out_byte_unloaded,
	output logic irq
);
	localparam int N = ubiec_pkg::EP_N;
	localparam int LW = ubiec_pkg::LEN_W;

	logic [ubiec_pkg::SEL_W-1:0] sel;
	logic [ubiec_pkg::SEL_W-1:0] idx;
	logic [ubiec_pkg::SEL_W-1:0] lk_idx;
	logic sel_ok;
	logic lk_ok;
	logic [7:0] wd;

	logic in_auto [N];
	logic in_iso [N];
	logic in_force [N];
	logic in_dbl [N];
	logic [1:0] in_rsv [N];
	logic [7:0] in_max [N];
	logic [1:0] in_pkts [N];
	logic [LW-1:0] in_load [N];
	logic in_tog [N];
	logic in_wait [N];
	logic out_auto [N];
	logic out_iso [N];
	logic out_dbl [N];
	logic [7:0] out_max [N];
	logic [1:0] out_pkts [N];
	logic [LW-1:0] out_len0 [N];
	logic [LW-1:0] out_len1 [N];
	logic [LW-1:0] out_unl [N];
	logic out_tog [N];
	logic out_sent_stall [N];
	logic out_send_stall [N];
	logic out_err [N];
	logic out_ovr [N];

	logic [N-1:0] ev_in_pop;
	logic [N-1:0] ev_in_wait;
	logic [N-1:0] ev_in_clrwait;
	logic [N-1:0] ev_out_push;
	logic [N-1:0] ev_out_stall;
	logic [N-1:0] ev_out_ovr;
	logic next_hs_valid;
	ubiec_pkg::ubiec_hs_t next_hs_code;
	logic next_hs_data1;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] irq_set;
	logic [7:0] next_rdata;

	assign wd = reg_wdata;
	assign sel_ok = sel >= ubiec_pkg::EP_SEL_MIN && sel <= ubiec_pkg::EP_SEL_MAX;
	assign idx = sel - ubiec_pkg::EP_SEL_MIN;
	assign lk_ok = link.tok_ep >= ubiec_pkg::EP_SEL_MIN && link.tok_ep <= ubiec_pkg::EP_SEL_MAX;
	assign lk_idx = link.tok_ep - ubiec_pkg::EP_SEL_MIN;

	// one token decoded per cycle; answer goes out on the next edge
	always_comb begin
		ev_in_pop = '0;
		ev_in_wait = '0;
		ev_in_clrwait = '0;
		ev_out_push = '0;
		ev_out_stall = '0;
		ev_out_ovr = '0;
		next_hs_valid = 1'b0;
		next_hs_code = ubiec_pkg::HS_NAK;
		next_hs_data1 = 1'b0;
		if (link.tok_valid && lk_ok) begin
			case (link.tok_kind)
				ubiec_pkg::TOK_IN: begin
					next_hs_valid = 1'b1;
					ev_in_clrwait[lk_idx] = 1'b1;
					if (in_pkts[lk_idx] != '0) begin
						next_hs_code = ubiec_pkg::HS_DATA;
						next_hs_data1 = in_tog[lk_idx];
						// iso gets no ack; forced flip drops without waiting
						if (in_iso[lk_idx] || in_force[lk_idx]) begin
							ev_in_pop[lk_idx] = 1'b1;
						end else begin
							ev_in_wait[lk_idx] = 1'b1;
						end
					end else if (in_iso[lk_idx]) begin
						next_hs_code = ubiec_pkg::HS_DATA;
					end
				end
				ubiec_pkg::TOK_ACK: begin
					ev_in_pop[lk_idx] = in_wait[lk_idx];
				end
				ubiec_pkg::TOK_OUT: begin
					if (out_send_stall[lk_idx] && !out_iso[lk_idx]) begin
						next_hs_valid = 1'b1;
						next_hs_code = ubiec_pkg::HS_STALL;
						ev_out_stall[lk_idx] = 1'b1;
					end else if (out_pkts[lk_idx] == (out_dbl[lk_idx] ?
							ubiec_pkg::TWO_PKT : ubiec_pkg::ONE_PKT)) begin
						if (out_iso[lk_idx]) begin
							ev_out_ovr[lk_idx] = 1'b1;
						end else begin
							next_hs_valid = 1'b1;
						end
					end else if (out_iso[lk_idx]) begin
						ev_out_push[lk_idx] = 1'b1;
					end else if (!link.tok_err) begin
						// corrupted bulk packets get silence so the host retries
						next_hs_valid = 1'b1;
						next_hs_code = ubiec_pkg::HS_ACK;
						ev_out_push[lk_idx] = link.tok_data1 == out_tog[lk_idx];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			link.hs_valid <= 1'b0;
			link.hs_code <= ubiec_pkg::HS_NAK;
			link.hs_data1 <= 1'b0;
		end else begin
			link.hs_valid <= next_hs_valid;
			link.hs_code <= next_hs_code;
			link.hs_data1 <= next_hs_data1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sel <= '0;
		end else if (reg_wr && reg_addr == ubiec_pkg::ADDR_EP_SELECT) begin
			sel <= wd[ubiec_pkg::SEL_W-1:0];
		end
	end

	genvar e;
	generate
		for (e = 0; e < N; e++) begin : g_ep
			logic hit;
			logic [1:0] in_cap;
			logic [1:0] out_cap;
			logic in_commit;
			logic out_pop;
			logic wr_outl;
			assign hit = sel_ok && idx == ubiec_pkg::SEL_W'(e);
			assign in_cap = in_dbl[e] ? ubiec_pkg::TWO_PKT : ubiec_pkg::ONE_PKT;
			assign out_cap = out_dbl[e] ? ubiec_pkg::TWO_PKT : ubiec_pkg::ONE_PKT;
			assign wr_outl = reg_wr && hit && reg_addr == ubiec_pkg::ADDR_OUT_CTRL_LOW;
			assign in_commit = in_pkts[e] != in_cap && ((reg_wr && hit &&
				reg_addr == ubiec_pkg::ADDR_IN_READY && wd[ubiec_pkg::IN_READY_BIT]) ||
				(in_auto[e] && hit && in_byte_loaded &&
				LW'(in_load[e] + 11'h1) == {in_max[e], 3'h0}));
			// flush, release by writing zero, or auto-release each pop one packet
			assign out_pop = out_pkts[e] != '0 && ((wr_outl &&
				(wd[ubiec_pkg::OUT_FLUSH_BIT] || !wd[ubiec_pkg::OUT_READY_BIT])) ||
				(out_auto[e] && hit && out_byte_unloaded &&
				LW'(out_unl[e] + 11'h1) == {out_max[e], 3'h0}));

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					in_auto[e] <= 1'b0;
					in_iso[e] <= 1'b0;
					in_rsv[e] <= ubiec_pkg::IN_RSV_RESET;
					in_force[e] <= 1'b0;
					in_dbl[e] <= 1'b0;
					in_max[e] <= '0;
					out_auto[e] <= 1'b0;
					out_iso[e] <= 1'b0;
					out_dbl[e] <= 1'b0;
					out_max[e] <= '0;
				end else if (reg_wr && hit) begin
					if (reg_addr == ubiec_pkg::ADDR_IN_CTRL_HIGH) begin
						in_auto[e] <= wd[ubiec_pkg::IN_AUTO_BIT];
						in_iso[e] <= wd[ubiec_pkg::IN_ISO_BIT];
						in_rsv[e] <= wd[ubiec_pkg::IN_RSV_HI:ubiec_pkg::IN_RSV_LO];
						in_force[e] <= wd[ubiec_pkg::IN_FORCE_BIT];
						in_dbl[e] <= wd[ubiec_pkg::IN_DBL_BIT];
					end
					if (reg_addr == ubiec_pkg::ADDR_IN_MAX) begin
						in_max[e] <= wd;
					end
					if (reg_addr == ubiec_pkg::ADDR_OUT_MAX) begin
						out_max[e] <= wd;
					end
					if (reg_addr == ubiec_pkg::ADDR_OUT_CONFIG) begin
						out_auto[e] <= wd[ubiec_pkg::OUTC_AUTO_BIT];
						out_iso[e] <= wd[ubiec_pkg::OUTC_ISO_BIT];
						out_dbl[e] <= wd[ubiec_pkg::OUTC_DBL_BIT];
					end
				end
			end

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					in_pkts[e] <= '0;
					in_load[e] <= '0;
					in_tog[e] <= 1'b0;
					in_wait[e] <= 1'b0;
				end else begin
					in_pkts[e] <= 2'(in_pkts[e] + {1'b0, in_commit} - {1'b0, ev_in_pop[e]});
					if (in_commit) begin
						in_load[e] <= '0;
					end else if (hit && in_byte_loaded) begin
						in_load[e] <= LW'(in_load[e] + 11'h1);
					end
					if (ev_in_pop[e]) begin
						in_tog[e] <= !in_tog[e];
					end
					in_wait[e] <= ev_in_wait[e] || (in_wait[e] && !ev_in_pop[e] &&
						!ev_in_clrwait[e]);
				end
			end

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					out_pkts[e] <= '0;
					out_len0[e] <= '0;
					out_len1[e] <= '0;
					out_unl[e] <= '0;
				end else begin
					out_pkts[e] <= 2'(out_pkts[e] + {1'b0, ev_out_push[e]} - {1'b0, out_pop});
					if (ev_out_push[e] && (out_pkts[e] == '0 ||
							(out_pkts[e] == ubiec_pkg::ONE_PKT && out_pop))) begin
						out_len0[e] <= link.tok_len;
					end else if (out_pop) begin
						out_len0[e] <= out_len1[e];
					end
					if (ev_out_push[e] && out_pkts[e] != '0) begin
						out_len1[e] <= link.tok_len;
					end
					if (out_pop) begin
						out_unl[e] <= '0;
					end else if (hit && out_byte_unloaded) begin
						out_unl[e] <= LW'(out_unl[e] + 11'h1);
					end
				end
			end

			// hardware sets win over software clears in the same cycle, but a toggle reset write beats a push's toggle flip
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					out_tog[e] <= 1'b0;
					out_sent_stall[e] <= 1'b0;
					out_send_stall[e] <= 1'b0;
					out_err[e] <= 1'b0;
					out_ovr[e] <= 1'b0;
				end else begin
					if (wr_outl && wd[ubiec_pkg::OUT_TOG_RST_BIT]) begin
						out_tog[e] <= 1'b0;
					end else if (ev_out_push[e] && !out_iso[e]) begin
						out_tog[e] <= !out_tog[e];
					end
					if (ev_out_stall[e]) begin
						out_sent_stall[e] <= 1'b1;
					end else if (wr_outl && !wd[ubiec_pkg::OUT_SENT_STALL_BIT]) begin
						out_sent_stall[e] <= 1'b0;
					end
					if (wr_outl) begin
						out_send_stall[e] <= wd[ubiec_pkg::OUT_SEND_STALL_BIT];
					end
					if (ev_out_push[e] && link.tok_err) begin
						out_err[e] <= 1'b1;
					end else if (out_pop) begin
						out_err[e] <= 1'b0;
					end
					if (ev_out_ovr[e]) begin
						out_ovr[e] <= 1'b1;
					end else if (wr_outl && !wd[ubiec_pkg::OUT_OVR_BIT]) begin
						out_ovr[e] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		irq_set = '0;
		irq_set[N-1:0] = ev_out_stall | ev_out_push;
		irq_set[ubiec_pkg::IRQ_IN_BIT] = |ev_in_pop;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
			irq_mask <= '0;
		end else begin
			if (reg_wr && reg_addr == ubiec_pkg::ADDR_IRQ_STATUS) begin
				irq_status <= (irq_status & ~wd) | irq_set;
			end else begin
				irq_status <= irq_status | irq_set;
			end
			if (reg_wr && reg_addr == ubiec_pkg::ADDR_IRQ_MASK) begin
				irq_mask <= wd;
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// self-clearing command bits are never stored, so they read as zero
	always_comb begin
		next_rdata = '0;
		if (reg_addr == ubiec_pkg::ADDR_EP_SELECT) begin
			next_rdata[ubiec_pkg::SEL_W-1:0] = sel;
		end else if (reg_addr == ubiec_pkg::ADDR_IRQ_STATUS) begin
			next_rdata = irq_status;
		end else if (reg_addr == ubiec_pkg::ADDR_IRQ_MASK) begin
			next_rdata = irq_mask;
		end else if (sel_ok) begin
			case (reg_addr)
				ubiec_pkg::ADDR_IN_CTRL_HIGH: begin
					next_rdata[ubiec_pkg::IN_AUTO_BIT] = in_auto[idx];
					next_rdata[ubiec_pkg::IN_ISO_BIT] = in_iso[idx];
					next_rdata[ubiec_pkg::IN_RSV_HI:ubiec_pkg::IN_RSV_LO] = in_rsv[idx];
					next_rdata[ubiec_pkg::IN_FORCE_BIT] = in_force[idx];
					next_rdata[ubiec_pkg::IN_DBL_BIT] = in_dbl[idx];
				end
				ubiec_pkg::ADDR_IN_MAX: next_rdata = in_max[idx];
				ubiec_pkg::ADDR_IN_READY: next_rdata[ubiec_pkg::IN_READY_BIT] = in_pkts[idx] != '0;
				ubiec_pkg::ADDR_OUT_MAX: next_rdata = out_max[idx];
				ubiec_pkg::ADDR_OUT_CONFIG: begin
					next_rdata[ubiec_pkg::OUTC_AUTO_BIT] = out_auto[idx];
					next_rdata[ubiec_pkg::OUTC_ISO_BIT] = out_iso[idx];
					next_rdata[ubiec_pkg::OUTC_DBL_BIT] = out_dbl[idx];
				end
				ubiec_pkg::ADDR_OUT_CTRL_LOW: begin
					next_rdata[ubiec_pkg::OUT_SENT_STALL_BIT] = out_sent_stall[idx];
					next_rdata[ubiec_pkg::OUT_SEND_STALL_BIT] = out_send_stall[idx];
					next_rdata[ubiec_pkg::OUT_ERR_BIT] = out_err[idx];
					next_rdata[ubiec_pkg::OUT_OVR_BIT] = out_ovr[idx];
					next_rdata[ubiec_pkg::OUT_FULL_BIT] = out_pkts[idx] ==
						(out_dbl[idx] ? ubiec_pkg::TWO_PKT : ubiec_pkg::ONE_PKT);
					next_rdata[ubiec_pkg::OUT_READY_BIT] = out_pkts[idx] != '0;
				end
				ubiec_pkg::ADDR_CNT_LOW: begin
					if (out_pkts[idx] != '0) begin
						next_rdata = out_len0[idx][7:0];
					end
				end
				ubiec_pkg::ADDR_CNT_HIGH: begin
					if (out_pkts[idx] != '0) begin
						next_rdata[LW-9:0] = out_len0[idx][LW-1:8];
					end
				end
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : '0;
		end
	end
endmodule

// *** verilog/ubiec_host.sv ***
`timescale 1ns/1ps
module ubiec_host (
	input wire logic clk_sys,
	input wire logic rst_n,
	ubiec_link_if.host link,
	input wire logic cmd_valid,
	input wire logic cmd_is_in,
	input wire logic cmd_iso,
	input wire logic [ubiec_pkg::SEL_W-1:0] cmd_ep,
	input wire logic [ubiec_pkg::LEN_W-1:0] cmd_len,
	input wire logic cmd_err,
	output logic cmd_ready,
	output logic res_valid,
	output ubiec_pkg::ubiec_hs_t res_code,
	output logic res_data1,
	output logic res_timeout
);
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACK} ubiec_hstate_t;

	ubiec_hstate_t state;
	logic [4:0] wait_cnt;
	logic is_in;
	logic iso;
	logic [ubiec_pkg::SEL_W-1:0] ep;
	logic out_tog [ubiec_pkg::EP_N+1];

	assign cmd_ready = state == H_IDLE;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= H_IDLE;
			wait_cnt <= '0;
			is_in <= 1'b0;
			iso <= 1'b0;
			ep <= '0;
			link.tok_valid <= 1'b0;
			link.tok_kind <= ubiec_pkg::TOK_OUT;
			link.tok_ep <= '0;
			link.tok_data1 <= 1'b0;
			link.tok_len <= '0;
			link.tok_err <= 1'b0;
			res_valid <= 1'b0;
			res_code <= ubiec_pkg::HS_NAK;
			res_data1 <= 1'b0;
			res_timeout <= 1'b0;
		end else begin
			link.tok_valid <= 1'b0;
			res_valid <= 1'b0;
			case (state)
				H_IDLE: begin
					if (cmd_valid) begin
						link.tok_valid <= 1'b1;
						link.tok_kind <= cmd_is_in ? ubiec_pkg::TOK_IN : ubiec_pkg::TOK_OUT;
						link.tok_ep <= cmd_ep;
						link.tok_data1 <= out_tog[cmd_ep];
						link.tok_len <= cmd_len;
						link.tok_err <= cmd_err;
						is_in <= cmd_is_in;
						iso <= cmd_iso;
						ep <= cmd_ep;
						wait_cnt <= '0;
						state <= H_WAIT;
					end
				end
				H_WAIT: begin
					wait_cnt <= 5'(wait_cnt + 5'h1);
					if (link.hs_valid) begin
						res_code <= link.hs_code;
						res_data1 <= link.hs_data1;
						res_timeout <= 1'b0;
						// bulk IN data is acknowledged before the result is reported
						if (is_in && !iso && link.hs_code == ubiec_pkg::HS_DATA) begin
							link.tok_valid <= 1'b1;
							link.tok_kind <= ubiec_pkg::TOK_ACK;
							state <= H_ACK;
						end else begin
							res_valid <= 1'b1;
							state <= H_IDLE;
						end
					end else if (wait_cnt == ubiec_pkg::HOST_WAIT_CYC - 5'h1) begin
						// iso OUT never gets a handshake, so this is its normal end
						res_timeout <= 1'b1;
						res_valid <= 1'b1;
						state <= H_IDLE;
					end
				end
				H_ACK: begin
					res_valid <= 1'b1;
					state <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// host-side OUT toggle per endpoint, moves only on an ACK
	genvar g;
	generate
		for (g = 0; g <= ubiec_pkg::EP_N; g++) begin : g_tog
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					out_tog[g] <= 1'b0;
				end else if (state == H_WAIT && link.hs_valid && !is_in &&
						ep == ubiec_pkg::SEL_W'(g) && link.hs_code == ubiec_pkg::HS_ACK) begin
					out_tog[g] <= !out_tog[g];
				end
			end
		end
	endgenerate
endmodule

// *** verilog/ubiec_link_if.sv ***
`timescale 1ns/1ps
interface ubiec_link_if;
	logic tok_valid;
	ubiec_pkg::ubiec_tok_t tok_kind;
	logic [ubiec_pkg::SEL_W-1:0] tok_ep;
	logic tok_data1;
	logic [ubiec_pkg::LEN_W-1:0] tok_len;
	logic tok_err;
	logic hs_valid;
	ubiec_pkg::ubiec_hs_t hs_code;
	logic hs_data1;

	modport dev (
		input tok_valid, tok_kind, tok_ep, tok_data1, tok_len, tok_err,
		output hs_valid, hs_code, hs_data1
	);
	modport host (
		output tok_valid, tok_kind, tok_ep, tok_data1, tok_len, tok_err,
		input hs_valid, hs_code, hs_data1
	);
endinterface

// *** verilog/ubiec_pkg.sv ***
package ubiec_pkg;
	localparam int EP_N = 5;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int LEN_W = 11;
	localparam int SEL_W = 3;

	localparam logic [ADDR_W-1:0] ADDR_IN_CTRL_HIGH = 16'hde12;
	localparam logic [ADDR_W-1:0] ADDR_OUT_MAX = 16'hde13;
	localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL_LOW = 16'hde14;
	localparam logic [ADDR_W-1:0] ADDR_EP_SELECT = 16'hde30;
	localparam logic [ADDR_W-1:0] ADDR_IN_MAX = 16'hde31;
	localparam logic [ADDR_W-1:0] ADDR_IN_READY = 16'hde32;
	localparam logic [ADDR_W-1:0] ADDR_OUT_CONFIG = 16'hde33;
	localparam logic [ADDR_W-1:0] ADDR_CNT_LOW = 16'hde34;
	localparam logic [ADDR_W-1:0] ADDR_CNT_HIGH = 16'hde35;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 16'hde36;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'hde37;

	localparam logic [SEL_W-1:0] EP_SEL_MIN = 3'h1;
	localparam logic [SEL_W-1:0] EP_SEL_MAX = 3'h5;

	localparam int IN_AUTO_BIT = 7;
	localparam int IN_ISO_BIT = 6;
	localparam int IN_RSV_HI = 5;
	localparam int IN_RSV_LO = 4;
	localparam int IN_FORCE_BIT = 3;
	localparam int IN_DBL_BIT = 0;
	localparam logic [1:0] IN_RSV_RESET = 2'h2;
	localparam int IN_READY_BIT = 0;

	localparam int OUT_TOG_RST_BIT = 7;
	localparam int OUT_SENT_STALL_BIT = 6;
	localparam int OUT_SEND_STALL_BIT = 5;
	localparam int OUT_FLUSH_BIT = 4;
	localparam int OUT_ERR_BIT = 3;
	localparam int OUT_OVR_BIT = 2;
	localparam int OUT_FULL_BIT = 1;
	localparam int OUT_READY_BIT = 0;

	localparam int OUTC_AUTO_BIT = 7;
	localparam int OUTC_ISO_BIT = 6;
	localparam int OUTC_DBL_BIT = 0;

	localparam int IRQ_IN_BIT = 5;
	localparam logic [1:0] ONE_PKT = 2'h1;
	localparam logic [1:0] TWO_PKT = 2'h2;
	localparam logic [4:0] HOST_WAIT_CYC = 5'h10;

	typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_ACK} ubiec_tok_t;
	typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} ubiec_hs_t;
endpackage
